// [rtl/tthr_map.vh]
// register map, field positions, reset values and link constants of the threshold register block
// Functional notes
// - local hysteresis register, RW, resets 4Ch
// - local setpoint register, RW, resets 51h
// - remote 1 result, read-only, resets 00h
// - remote 1 result updates after complete conversion
// - remote 1 hysteresis register, RW, resets 5Ch
// - two's complement, one degree per bit
// - local above setpoint/below hysteresis sets flag
// - remote above setpoint/below hysteresis sets flag
// - event needs fault-queue consecutive conversions
`ifndef TTHR_MAP_VH
`define TTHR_MAP_VH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define TTHR_IDX_LOCAL_RESULT 6'h00
`define TTHR_IDX_CONFIG 6'h01
`define TTHR_IDX_LOCAL_HYST 6'h02
`define TTHR_IDX_LOCAL_SET 6'h03
`define TTHR_IDX_REMOTE_RESULT 6'h10
`define TTHR_IDX_REMOTE_HYST 6'h12
`define TTHR_IDX_REMOTE_SET 6'h13
`define TTHR_IDX_STATUS 6'h14
`define TTHR_IDX_MASK 6'h15

// ************************************************************
// reset values
// ************************************************************
`define TTHR_RST_RESULT 8'h00
`define TTHR_RST_LOCAL_HYST 8'h4c
`define TTHR_RST_LOCAL_SET 8'h51
`define TTHR_RST_REMOTE_HYST 8'h5c
`define TTHR_RST_REMOTE_SET 8'h61
`define TTHR_RST_CONFIG 2'h0
`define TTHR_RST_MASK 2'h3

// ************************************************************
// config fields and fault queue depths
// ************************************************************
`define TTHR_CFG_IM 2
`define TTHR_CFG_FQ_LO 3
`define TTHR_CFG_FQ_HI 4
`define TTHR_FQ_DEPTH_0 4'h1
`define TTHR_FQ_DEPTH_1 4'h2
`define TTHR_FQ_DEPTH_2 4'h4
`define TTHR_FQ_DEPTH_3 4'h6
`define TTHR_FQ_CNT_MAX 3'h7

// ************************************************************
// converter link frame: zone bit then 8 temperature bits, msb first
// ************************************************************
`define TTHR_FRAME_BITS 4'h9
`define TTHR_FRAME_ZONE_BIT 8
`define TTHR_ZONE_LOCAL 1'h0
`define TTHR_ZONE_REMOTE 1'h1

`endif

// [rtl/tthr_regs.v]
// temperature threshold registers with apb slave, converter link and event interrupt
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "tthr_map.vh"

module tthr_regs #(
  parameter ADDR_W = 8
) (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_adc_clk,
  input wire i_adc_frame,
  input wire i_adc_data,
  output reg o_irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg [7:0] local_temperature_result;
  reg [7:0] remote1_temperature_result;
  reg [7:0] local_hyst_threshold;
  reg [7:0] local_high_setpoint;
  reg [7:0] remote1_hyst_threshold;
  reg [7:0] remote1_high_setpoint;
  reg [1:0] fault_queue_sel;
  reg irq_disable;
  reg [1:0] event_flags;
  reg [1:0] event_mask;
  reg [2:0] clk_sync;
  reg [2:0] frame_sync;
  reg [1:0] data_sync;
  reg [8:0] frame_shift;
  reg [3:0] frame_bits;
  reg conv_valid;
  reg conv_zone;
  reg [7:0] conv_temp;
  reg [7:0] rd_value;
  reg rd_hit;
  reg [3:0] fq_depth;
  reg [1:0] next_event_flags;
  wire [5:0] reg_idx;
  wire access;
  wire wr_fire;
  wire link_clk_rise;
  wire frame_rise;
  wire frame_fall;
  wire [1:0] zone_event;
  wire [15:0] zone_set;
  wire [15:0] zone_hyst;

  // ************************************************************
  // one-hot state codes
  // ************************************************************
  localparam [2:0] RX_IDLE = 3'b001;
  localparam [2:0] RX_SHIFT = 3'b010;
  localparam [2:0] RX_POST = 3'b100;
  localparam [1:0] BUS_IDLE = 2'b01;
  localparam [1:0] BUS_ANSWER = 2'b10;
  reg [2:0] rx_state;
  reg [2:0] next_rx_state;
  reg [1:0] bus_state;
  reg [1:0] next_bus_state;

  assign reg_idx = i_paddr[7:2];
  assign access = i_psel & i_penable;
  assign wr_fire = access & o_pready & i_pwrite;

  // ************************************************************
  // converter link synchronisers
  // ************************************************************
  // stage 0 feeds only stage 1; edge detection looks at stages 1 and 2
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      clk_sync <= 3'h0;
      frame_sync <= 3'h0;
      data_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], i_adc_clk};
      frame_sync <= {frame_sync[1:0], i_adc_frame};
      data_sync <= {data_sync[0], i_adc_data};
    end
  end

  assign link_clk_rise = clk_sync[1] & ~clk_sync[2];
  assign frame_rise = frame_sync[1] & ~frame_sync[2];
  assign frame_fall = ~frame_sync[1] & frame_sync[2];

  // ************************************************************
  // frame receiver state
  // ************************************************************
  // a result is posted only for a fall that closes a frame whose rise was seen,
  // so a lone fall on the frame pin never loads a stale shift register
  always @* begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE: begin
        if (frame_rise) begin
          next_rx_state = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (frame_fall) begin
          next_rx_state = RX_POST;
        end
      end
      RX_POST: begin
        if (frame_rise) begin
          next_rx_state = RX_SHIFT;
        end else begin
          next_rx_state = RX_IDLE;
        end
      end
      default: begin
        next_rx_state = RX_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_state <= RX_IDLE;
    end else begin
      rx_state <= next_rx_state;
    end
  end

  // ************************************************************
  // frame shifter
  // ************************************************************
  // data and clock pass equal sync depth, so the sampled bit lines up with its edge
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      frame_shift <= 9'h000;
      frame_bits <= 4'h0;
    end else if (frame_rise) begin
      frame_bits <= 4'h0;
    end else if (frame_sync[1] && link_clk_rise) begin
      frame_shift <= {frame_shift[7:0], data_sync[1]};
      if (frame_bits != 4'hf) begin
        frame_bits <= frame_bits + 4'h1;
      end
    end
  end

  // a short or overlong frame is dropped, so results only move on a whole conversion
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      conv_valid <= 1'b0;
      conv_zone <= 1'b0;
      conv_temp <= 8'h00;
    end else begin
      conv_valid <= frame_fall && (rx_state == RX_SHIFT) && (frame_bits == `TTHR_FRAME_BITS);
      if (frame_fall) begin
        conv_zone <= frame_shift[`TTHR_FRAME_ZONE_BIT];
        conv_temp <= frame_shift[7:0];
      end
    end
  end

  // ************************************************************
  // result registers
  // ************************************************************
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      local_temperature_result <= `TTHR_RST_RESULT;
      remote1_temperature_result <= `TTHR_RST_RESULT;
    end else if (conv_valid) begin
      if (conv_zone == `TTHR_ZONE_LOCAL) begin
        local_temperature_result <= conv_temp;
      end else begin
        remote1_temperature_result <= conv_temp;
      end
    end
  end

  // ************************************************************
  // fault queue and threshold comparison per zone
  // ************************************************************
  always @* begin
    case (fault_queue_sel)
      2'h0: fq_depth = `TTHR_FQ_DEPTH_0;
      2'h1: fq_depth = `TTHR_FQ_DEPTH_1;
      2'h2: fq_depth = `TTHR_FQ_DEPTH_2;
      default: fq_depth = `TTHR_FQ_DEPTH_3;
    endcase
  end

  assign zone_set = {remote1_high_setpoint, local_high_setpoint};
  assign zone_hyst = {remote1_hyst_threshold, local_hyst_threshold};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_zone
      localparam [0:0] ZID = g;
      reg [2:0] fq_cnt;
      wire mine;
      wire cond;
      wire [3:0] run_len;
      assign mine = conv_valid && (conv_zone == ZID);
      // signed compare: values are two's complement degrees
      assign cond = ($signed(conv_temp) > $signed(zone_set[g*8 +: 8])) ||
                    ($signed(conv_temp) < $signed(zone_hyst[g*8 +: 8]));
      assign run_len = {1'b0, fq_cnt} + 4'h1;
      assign zone_event[g] = mine && cond && (run_len >= fq_depth);
      always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          fq_cnt <= 3'h0;
        end else if (mine) begin
          if (!cond) begin
            fq_cnt <= 3'h0;
          end else if (fq_cnt != `TTHR_FQ_CNT_MAX) begin
            fq_cnt <= fq_cnt + 3'h1;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // apb write side
  // ************************************************************
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      local_hyst_threshold <= `TTHR_RST_LOCAL_HYST;
      local_high_setpoint <= `TTHR_RST_LOCAL_SET;
      remote1_hyst_threshold <= `TTHR_RST_REMOTE_HYST;
      remote1_high_setpoint <= `TTHR_RST_REMOTE_SET;
      fault_queue_sel <= `TTHR_RST_CONFIG;
      irq_disable <= 1'b0;
      event_mask <= `TTHR_RST_MASK;
    end else if (wr_fire) begin
      case (reg_idx)
        `TTHR_IDX_LOCAL_HYST: local_hyst_threshold <= i_pwdata[7:0];
        `TTHR_IDX_LOCAL_SET: local_high_setpoint <= i_pwdata[7:0];
        `TTHR_IDX_REMOTE_HYST: remote1_hyst_threshold <= i_pwdata[7:0];
        `TTHR_IDX_REMOTE_SET: remote1_high_setpoint <= i_pwdata[7:0];
        `TTHR_IDX_CONFIG: begin
          fault_queue_sel <= i_pwdata[`TTHR_CFG_FQ_HI:`TTHR_CFG_FQ_LO];
          irq_disable <= i_pwdata[`TTHR_CFG_IM];
        end
        `TTHR_IDX_MASK: event_mask <= i_pwdata[1:0];
        // result registers are read-only: a write there changes nothing
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // sticky event flags and interrupt
  // ************************************************************
  // a new event in the clearing cycle survives, so no event is lost
  always @* begin
    next_event_flags = event_flags;
    if (wr_fire && (reg_idx == `TTHR_IDX_STATUS)) begin
      next_event_flags = event_flags & ~i_pwdata[1:0];
    end
    next_event_flags = next_event_flags | zone_event;
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      event_flags <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      event_flags <= next_event_flags;
      o_irq <= ~irq_disable && |(event_flags & event_mask);
    end
  end

  // ************************************************************
  // apb answer state
  // ************************************************************
  // the answer state is the single wait state: ready rises one edge after the
  // access phase is seen, and a back-to-back setup finds the slave idle again
  always @* begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (access) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // ************************************************************
  // apb read side and handshake
  // ************************************************************
  always @* begin
    rd_hit = 1'b1;
    rd_value = 8'h00;
    case (reg_idx)
      `TTHR_IDX_LOCAL_RESULT: rd_value = local_temperature_result;
      `TTHR_IDX_CONFIG: rd_value = {3'h0, fault_queue_sel, irq_disable, 2'h0};
      `TTHR_IDX_LOCAL_HYST: rd_value = local_hyst_threshold;
      `TTHR_IDX_LOCAL_SET: rd_value = local_high_setpoint;
      `TTHR_IDX_REMOTE_RESULT: rd_value = remote1_temperature_result;
      `TTHR_IDX_REMOTE_HYST: rd_value = remote1_hyst_threshold;
      `TTHR_IDX_REMOTE_SET: rd_value = remote1_high_setpoint;
      `TTHR_IDX_STATUS: rd_value = {6'h00, event_flags};
      `TTHR_IDX_MASK: rd_value = {6'h00, event_mask};
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait state keeps every bus output a plain flop
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (next_bus_state == BUS_ANSWER) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
      o_pslverr <= ~rd_hit;
    end else begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

endmodule // tthr_regs

// [sim/tthr_regs_props.sv]
// port checker for the threshold register block
`timescale 1ns/1ps
module tthr_regs_props #(parameter ADDR_W = 8) (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_adc_clk,
  input wire i_adc_frame,
  input wire i_adc_data,
  input wire o_irq
);
  // ********
  // apb answer and data
  // ********
  wire [5:0] idx = i_paddr[7:2];
  wire hit = idx < 6'h04 || idx == 6'h10 || (idx > 6'h11 && idx < 6'h16);
  wire acc = i_psel && i_penable;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  a_ready_wait: assert property (acc && !o_pready |=> o_pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (o_pready |-> acc && $past(acc))
    else $error("ready without access phase");
  a_rdata_idle: assert property (!o_pready || i_pwrite |-> o_prdata == 32'h0)
    else $error("read data outside read answer");
  a_rdata_byte: assert property (o_prdata[31:8] == 24'h0)
    else $error("read data above bit 7");
  a_err_only: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_err_unmapped: assert property (o_pready && !hit |-> o_pslverr)
    else $error("unmapped address not refused");
  a_ok_mapped: assert property (o_pready && hit |-> !o_pslverr)
    else $error("mapped address refused");
  // shadow of the interrupt disable bit, taken from accepted config writes
  logic im_seen;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      im_seen <= 1'b0;
    end else if (acc && o_pready && i_pwrite && idx == 6'h01) begin
      im_seen <= i_pwdata[2];
    end
  end
  a_irq_disabled: assert property (im_seen |=> !o_irq)
    else $error("interrupt raised while disabled");
  c_err: cover property (o_pready && o_pslverr);
  c_write: cover property (o_pready && i_pwrite);
  c_irq: cover property ($rose(o_irq));
endmodule // tthr_regs_props
bind tthr_regs tthr_regs_props #(.ADDR_W(ADDR_W)) u_tthr_regs_props (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_adc_clk(i_adc_clk),
  .i_adc_frame(i_adc_frame), .i_adc_data(i_adc_data), .o_irq(o_irq));

// [sim/tthr_adc_model.sv]
// converter link source for the threshold register bench
`timescale 1ns/1ps
module tthr_adc_model (
  output logic o_clk,
  output logic o_frame,
  output logic o_data
);
  initial begin
    o_clk = 1'h0;
    o_frame = 1'h0;
    o_data = 1'h0;
  end
  // zone bit then two's complement degrees, msb first; a short count tests frame dropping
  task automatic send(input logic zone, input logic [7:0] temp, input int nbits);
    logic [8:0] w;
    w = {zone, temp};
    // start off the system clock edges
    #13;
    o_frame = 1'h1;
    #400;
    for (int i = 0; i < nbits; i++) begin
      o_data = w[8-i];
      #400 o_clk = 1'h1;
      #400 o_clk = 1'h0;
    end
    #400 o_frame = 1'h0;
    // released line must not keep the last bit
    o_data = ~o_data;
    #1000;
  endtask
endmodule // tthr_adc_model

// [sim/tb_temp_threshold_registers.sv]
// self-checking bench for the threshold register block
`timescale 1ns/1ps
module tb_temp_threshold_registers;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, rerr;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, irq, aclk, afrm, adat;
  logic [7:0] ra [8] = '{8'h08, 8'h0c, 8'h40, 8'h48, 8'h4c, 8'h04, 8'h54, 8'h50};
  logic [7:0] rv [8] = '{8'h4c, 8'h51, 8'h00, 8'h5c, 8'h61, 8'h00, 8'h03, 8'h00};
  logic [7:0] wa [3] = '{8'h08, 8'h0c, 8'h48};
  logic [7:0] wv [3] = '{8'hf6, 8'h14, 8'h80};
  int num_errors = 0, checks_done = 0, cyc = 0;
  tthr_regs u_tthr_regs (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_adc_clk(aclk), .i_adc_frame(afrm), .i_adc_data(adat), .o_irq(irq));
  tthr_adc_model u_tthr_adc_model (.o_clk(aclk), .o_frame(afrm), .o_data(adat));
  // ********
  // bus tasks and checks
  // ********
  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    // only pready or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++)
      rd(ra[i], {24'h0, rv[i]});
    u_tthr_adc_model.send(1'h1, 8'he7, 8);
    rd(8'h40, 32'h0);
    u_tthr_adc_model.send(1'h1, 8'he7, 9);
    rd(8'h40, 32'he7);
    rd(8'h50, 32'h2);
    irqchk(1'h1);
    apb(1'h1, 8'h40, 32'h33);
    chk({31'h0, rerr}, 32'h0);
    rd(8'h40, 32'he7);
    rd(8'h48, 32'h5c);
    apb(1'h1, 8'h54, 32'h1);
    irqchk(1'h0);
    apb(1'h1, 8'h50, 32'h2);
    rd(8'h50, 32'h0);
    apb(1'h1, 8'h54, 32'h3);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, wa[i], {24'hffffff, wv[i]});
      rd(wa[i], {24'h0, wv[i]});
    end
    // fault queue of two conversions
    apb(1'h1, 8'h04, 32'h8);
    u_tthr_adc_model.send(1'h0, 8'h15, 9);
    rd(8'h50, 32'h0);
    u_tthr_adc_model.send(1'h0, 8'h15, 9);
    rd(8'h50, 32'h1);
    irqchk(1'h1);
    rd(8'h00, 32'h15);
    apb(1'h1, 8'h04, 32'hc);
    irqchk(1'h0);
    rd(8'hfc, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // mid-run reset must bring back the reset value of every register but the local result, which is not read
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++)
      rd(ra[i], {24'h0, rv[i]});
    complete_run();
  end
endmodule // tb_temp_threshold_registers
